// *** strc_counter.sv ***
// Counting core: scaled total, filtered rate, grand total and reset holds
`timescale 1ns/100ps
//
// Contract
// - Total shown is arithmetic count divided by the total divisor.
// - Total is computed apart from the rate path and its settings.
// - Changing the total divisor drops pulse, alarm and loop enables.
// - Rate shown is pulse rate divided by the rate divisor.
// - Changing the rate divisor drops pulse, alarm and loop enables.
// - Rate is scaled counts per selected time unit.
// - Timebase multiplies per-second rate by 1, 60 or 3600.
// - Tens digit picks rate smoothing time constant, 0 to 31.5 s.
// - Units digit picks step percent that bypasses smoothing; 0 is off.
// - While smoothing is edited the secondary output shows smoothed rate.
// - Direction setting makes each pulse count up or down.
// - Down counting starts from preset after reset, heading to zero.
// - Local or remote clear loads the preset, not zero.
// - Two front-panel clears, separately enabled, only in display mode.
// - Both buttons held over three seconds reload the total.
// - Remote contact closed over one second reloads the total.
// - Sixteen-digit grand total follows total, untouched by total clears.
// - Grand total is shown as two eight-digit halves.
// - Both buttons held over ten seconds zero the grand total.
// - Count mode derives count from both inputs, incl. A minus B.
module strc_counter
  import strc_pkg::*;
#(
  parameter int CYC_PER_MS = STRC_CYC_PER_MS
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_pulse_a,
  input wire logic i_pulse_b,
  input wire logic i_btn_up,
  input wire logic i_btn_dn,
  input wire logic i_remote_clear_terminal_a_n,
  input wire logic [1:0] i_count_mode,
  input wire logic i_count_down,
  input wire logic [1:0] i_timebase,
  input wire logic [16:0] i_total_divisor_mant,
  input wire logic [2:0] i_total_divisor_dp,
  input wire logic [16:0] i_rate_divisor_mant,
  input wire logic [2:0] i_rate_divisor_dp,
  input wire logic [3:0] i_smooth_tens,
  input wire logic [3:0] i_smooth_units,
  input wire logic i_smooth_editing,
  input wire logic signed [31:0] i_preset_load_value,
  input wire logic i_display_mode,
  input wire logic i_front_panel_total_clear,
  input wire logic i_front_panel_sum_clear,
  input wire logic i_pulse_out_enable,
  input wire logic i_alarm_enable,
  input wire logic i_loop_enable,
  output logic signed [31:0] o_total,
  output logic [31:0] o_rate,
  output logic [31:0] o_secondary,
  output logic [31:0] o_sum_upper,
  output logic [31:0] o_sum_lower,
  output logic o_pulse_out_en,
  output logic o_alarm_en,
  output logic o_loop_en
);
  typedef enum logic [1:0] {STRC_DV_IDLE, STRC_DV_TOT, STRC_DV_RATE} strc_dv_type;

  function automatic logic [63:0] strc_bcd_step(input logic [63:0] v, input logic up);
    logic [63:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      if (c)
      begin
        if (up)
        begin
          c = (r[4*i+:4] == 4'h9);
          r[4*i+:4] = c ? 4'h0 : r[4*i+:4] + 4'h1;
        end
        else
        begin
          c = (r[4*i+:4] == 4'h0);
          r[4*i+:4] = c ? 4'h9 : r[4*i+:4] - 4'h1;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] strc_pow10(input logic [2:0] dp);
    logic [13:0] p;
    p = 14'h0001;
    for (int i = 0; i < 4; i++)
    begin
      if (3'(i) < dp && dp <= STRC_DP_MAX)
      begin
        p = 14'(p * 14'h000A);
      end
    end
    return p;
  endfunction

  // Saturates one past the limit so a long hold fires only once
  function automatic logic [13:0] strc_hold_nxt(input logic [13:0] c, input logic cond,
                                               input logic tick, input logic [13:0] lim);
    if (!cond)
    begin
      return 14'h0000;
    end
    return (tick && c <= lim) ? c + 14'h0001 : c;
  endfunction

  // Pin inputs: two stages, then a third only for edge detection
  logic [4:0] sync1_r, sync2_r, sync3_r;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end
    else
    begin
      sync1_r <= {i_pulse_a, i_pulse_b, i_btn_up, i_btn_dn, ~i_remote_clear_terminal_a_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  logic rise_a, rise_b, lvl_b, both_btn, remote_shut;
  assign rise_a = sync2_r[4] & ~sync3_r[4];
  assign rise_b = sync2_r[3] & ~sync3_r[3];
  assign lvl_b = sync2_r[3];
  assign both_btn = sync2_r[2] & sync2_r[1];
  assign remote_shut = sync2_r[0];

  logic signed [2:0] raw_d, delta;
  always_comb
  begin
    raw_d = 3'sd0;
    case (strc_mode_type'(i_count_mode))
      STRC_ADD: raw_d = 3'(rise_a) + 3'(rise_b);
      STRC_SUB: raw_d = 3'(rise_a) - 3'(rise_b);
      STRC_BDIR: raw_d = rise_a ? (lvl_b ? -3'sd1 : 3'sd1) : 3'sd0;
      STRC_QUAD: raw_d = rise_a ? (lvl_b ? 3'sd1 : -3'sd1) : 3'sd0;
      default: raw_d = 3'sd0;
    endcase
    delta = i_count_down ? -raw_d : raw_d;
  end

  // Millisecond tick and hold timers
  logic [17:0] ms_cnt_r;
  logic tick;
  assign tick = (ms_cnt_r == 18'(CYC_PER_MS - 1));
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ms_cnt_r <= 18'h00000;
    else
      ms_cnt_r <= tick ? 18'h00000 : ms_cnt_r + 18'h00001;
  end
  logic tot_cond, sum_cond, tot_fire, sum_fire, rem_fire, clear_total;
  logic [13:0] tot_hold_r, sum_hold_r, rem_hold_r;
  assign tot_cond = both_btn & i_display_mode & i_front_panel_total_clear;
  assign sum_cond = both_btn & i_display_mode & i_front_panel_sum_clear;
  assign tot_fire = tot_cond & tick & (tot_hold_r == STRC_HOLD_TOTAL_MS);
  assign sum_fire = sum_cond & tick & (sum_hold_r == STRC_HOLD_SUM_MS);
  assign rem_fire = remote_shut & tick & (rem_hold_r == STRC_HOLD_REMOTE_MS);
  assign clear_total = tot_fire | rem_fire;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tot_hold_r <= 14'h0000;
      sum_hold_r <= 14'h0000;
      rem_hold_r <= 14'h0000;
    end
    else
    begin
      tot_hold_r <= strc_hold_nxt(tot_hold_r, tot_cond, tick, STRC_HOLD_TOTAL_MS);
      sum_hold_r <= strc_hold_nxt(sum_hold_r, sum_cond, tick, STRC_HOLD_SUM_MS);
      rem_hold_r <= strc_hold_nxt(rem_hold_r, remote_shut, tick, STRC_HOLD_REMOTE_MS);
    end
  end

  // Pulse count since the last clear; preset is added after scaling
  logic signed [31:0] count_r;
  logic [63:0] sum_r;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      count_r <= STRC_TOTAL_RST;
    else if (clear_total)
      count_r <= STRC_TOTAL_RST;
    else
      count_r <= count_r + 32'(delta);
  end
  // Grand total holds raw pulses in BCD, so halves need no division
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sum_r <= STRC_SUM_RST;
    else if (sum_fire)
      sum_r <= STRC_SUM_RST;
    else if (delta == 3'sd2)
      sum_r <= strc_bcd_step(strc_bcd_step(sum_r, 1'b1), 1'b1);
    else if (delta == -3'sd2)
      sum_r <= strc_bcd_step(strc_bcd_step(sum_r, 1'b0), 1'b0);
    else if (delta != 3'sd0)
      sum_r <= strc_bcd_step(sum_r, delta > 3'sd0);
  end

  // One-second gate measures the per-second rate
  logic [13:0] gate_ms_r;
  logic signed [23:0] gate_acc_r;
  logic [23:0] rate_raw_r;
  logic gate_end, rate_pend_r;
  assign gate_end = tick & (gate_ms_r == STRC_GATE_MS - 14'h0001);
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      gate_ms_r <= 14'h0000;
      gate_acc_r <= 24'sd0;
      rate_raw_r <= 24'h000000;
    end
    else
    begin
      if (tick)
        gate_ms_r <= gate_end ? 14'h0000 : gate_ms_r + 14'h0001;
      if (gate_end)
      begin
        gate_acc_r <= 24'(delta);
        rate_raw_r <= gate_acc_r < 0 ? 24'(-gate_acc_r) : 24'(gate_acc_r);
      end
      else
        gate_acc_r <= gate_acc_r + 24'(delta);
    end
  end

  // Shared serial divider: total and rate alternate, 48 steps each
  strc_dv_type dv_st_r;
  logic [47:0] dv_num_r;
  logic [17:0] dv_rem_r;
  logic [16:0] dv_den_r;
  logic [5:0] dv_cnt_r;
  logic dv_neg_r;
  logic dv_fresh_r;
  logic [17:0] rem_sh;
  logic [11:0] tb_mul;
  logic [16:0] tot_den, rate_den;
  assign rem_sh = {dv_rem_r[16:0], dv_num_r[47]};
  assign tot_den = (i_total_divisor_mant == 17'h00000) ? 17'h00001 : i_total_divisor_mant;
  assign rate_den = (i_rate_divisor_mant == 17'h00000) ? 17'h00001 : i_rate_divisor_mant;
  always_comb
  begin
    case (strc_tb_type'(i_timebase))
      STRC_PER_MIN: tb_mul = STRC_TB_MIN;
      STRC_PER_HOUR: tb_mul = STRC_TB_HOUR;
      default: tb_mul = STRC_TB_SEC;
    endcase
  end
  logic dv_done;
  assign dv_done = (dv_st_r != STRC_DV_IDLE) && (dv_cnt_r == STRC_DIV_STEPS - 6'h01);
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dv_st_r <= STRC_DV_IDLE;
      dv_num_r <= 48'h0;
      dv_rem_r <= 18'h0;
      dv_den_r <= 17'h00001;
      dv_cnt_r <= 6'h00;
      dv_neg_r <= 1'b0;
      dv_fresh_r <= 1'b0;
    end
    else
    begin
      case (dv_st_r)
        STRC_DV_IDLE:
        begin
          dv_st_r <= STRC_DV_TOT;
          dv_num_r <= 48'(count_r < 0 ? -count_r : count_r) * 48'(strc_pow10(i_total_divisor_dp));
          dv_den_r <= tot_den;
          dv_neg_r <= count_r < 0;
          dv_rem_r <= 18'h0;
          dv_cnt_r <= 6'h00;
        end
        STRC_DV_TOT, STRC_DV_RATE:
        begin
          dv_rem_r <= (rem_sh >= {1'b0, dv_den_r}) ? rem_sh - {1'b0, dv_den_r} : rem_sh;
          dv_num_r <= {dv_num_r[46:0], rem_sh >= {1'b0, dv_den_r}};
          dv_cnt_r <= dv_cnt_r + 6'h01;
          if (dv_done && dv_st_r == STRC_DV_TOT)
          begin
            dv_st_r <= STRC_DV_RATE;
            dv_num_r <= 48'(rate_raw_r * tb_mul) * 48'(strc_pow10(i_rate_divisor_dp));
            dv_den_r <= rate_den;
            // A rate division loaded before the gate closed carries last gate's count
            dv_fresh_r <= rate_pend_r;
            dv_rem_r <= 18'h0;
            dv_cnt_r <= 6'h00;
          end
          else if (dv_done)
            dv_st_r <= STRC_DV_IDLE;
        end
        default: dv_st_r <= STRC_DV_IDLE;
      endcase
    end
  end
  logic [31:0] quot;
  assign quot = {dv_num_r[30:0], rem_sh >= {1'b0, dv_den_r}};

  // Total result uses only its own divisor and the preset
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_total <= STRC_TOTAL_RST;
    else if (dv_done && dv_st_r == STRC_DV_TOT)
      o_total <= i_preset_load_value + (dv_neg_r ? -quot : quot);
  end

  // Rate smoothing, stepped once per gate when the new rate is ready
  logic [31:0] filt_r;
  logic signed [33:0] dev;
  logic [33:0] dev_abs;
  logic [8:0] alpha;
  logic [6:0] pct;
  assign alpha = STRC_ALPHA[i_smooth_tens > 4'h9 ? 4'h9 : i_smooth_tens];
  assign pct = STRC_STEP_PCT[i_smooth_units > 4'h9 ? 4'h9 : i_smooth_units];
  assign dev = $signed({2'b00, quot}) - $signed({2'b00, filt_r});
  assign dev_abs = dev < 0 ? 34'(-dev) : 34'(dev);
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rate_pend_r <= 1'b0;
    else if (gate_end)
      rate_pend_r <= 1'b1;
    else if (dv_fresh_r && dv_done && dv_st_r == STRC_DV_RATE)
      rate_pend_r <= 1'b0;
  end
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      filt_r <= 32'h0;
    else if (dv_fresh_r && dv_done && dv_st_r == STRC_DV_RATE)
    begin
      if (pct != 7'h00 && 41'(dev_abs) * 41'd100 > 41'(filt_r) * 41'(pct))
        filt_r <= quot;
      else
        filt_r <= 32'($signed({2'b00, filt_r}) + ((dev * $signed({1'b0, alpha})) >>> 8));
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rate <= 32'h0;
      o_secondary <= 32'h0;
      o_sum_upper <= 32'h0;
      o_sum_lower <= 32'h0;
    end
    else
    begin
      o_rate <= filt_r;
      o_secondary <= i_smooth_editing ? filt_r : o_total;
      o_sum_upper <= sum_r[63:32];
      o_sum_lower <= sum_r[31:0];
    end
  end

  // Divisor edits drop the output enables; the drop wins over a re-enable
  logic [19:0] tot_div_q_r, rate_div_q_r;
  logic div_change;
  assign div_change = (tot_div_q_r != {i_total_divisor_mant, i_total_divisor_dp}) ||
                      (rate_div_q_r != {i_rate_divisor_mant, i_rate_divisor_dp});
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tot_div_q_r <= 20'h0;
      rate_div_q_r <= 20'h0;
      o_pulse_out_en <= 1'b0;
      o_alarm_en <= 1'b0;
      o_loop_en <= 1'b0;
    end
    else
    begin
      tot_div_q_r <= {i_total_divisor_mant, i_total_divisor_dp};
      rate_div_q_r <= {i_rate_divisor_mant, i_rate_divisor_dp};
      o_pulse_out_en <= !div_change && (o_pulse_out_en || i_pulse_out_enable);
      o_alarm_en <= !div_change && (o_alarm_en || i_alarm_enable);
      o_loop_en <= !div_change && (o_loop_en || i_loop_enable);
    end
  end

  tot_clear_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tot_fire |-> $past(tot_cond, 8) && tot_hold_r > STRC_HOLD_TOTAL_MS - 14'h0001)
    else $error("total clear fired without a full hold");
  count_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    clear_total |=> count_r == 32'sd0)
    else $error("count not cleared after a clear");
  rem_short_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !remote_shut |-> !rem_fire ##1 rem_hold_r == 14'h0000)
    else $error("remote hold not restarted on release");
  sum_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    sum_fire |=> sum_r == STRC_SUM_RST)
    else $error("grand total not zeroed");
  sum_keep_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    clear_total && !sum_fire && delta == 3'sd0 |=> $stable(sum_r))
    else $error("grand total moved on a total clear");
  panel_mode_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_display_mode |-> !tot_fire && !sum_fire)
    else $error("panel clear outside display mode");
  enable_drop_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    div_change |=> !o_pulse_out_en && !o_alarm_en && !o_loop_en)
    else $error("outputs still enabled after divisor edit");
  div_length_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    dv_st_r == STRC_DV_IDLE |=> dv_st_r == STRC_DV_TOT [*8] ##40 dv_st_r == STRC_DV_TOT
    ##1 dv_st_r == STRC_DV_RATE)
    else $error("total division did not take 48 steps");
  live_rate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_smooth_editing |=> o_secondary == $past(filt_r))
    else $error("secondary output not showing smoothed rate");
  tot_clear_c: cover property (@(posedge i_clk) disable iff (!i_arst_n) tot_fire);
  rem_clear_c: cover property (@(posedge i_clk) disable iff (!i_arst_n) rem_fire);
  bypass_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    dv_fresh_r && dv_done && dv_st_r == STRC_DV_RATE && pct != 7'h00);
endmodule

// *** strc_pkg.sv ***
// Constants shared by the scaled total and rate counter
package strc_pkg;
  localparam int STRC_CLK_PERIOD_NS = 5;
  localparam int STRC_TICK_NS = 1_000_000;
  localparam int STRC_CYC_PER_MS = STRC_TICK_NS / STRC_CLK_PERIOD_NS;
  localparam logic [13:0] STRC_HOLD_TOTAL_MS = 14'h0BB8;
  localparam logic [13:0] STRC_HOLD_REMOTE_MS = 14'h03E8;
  localparam logic [13:0] STRC_HOLD_SUM_MS = 14'h2710;
  localparam logic [13:0] STRC_GATE_MS = 14'h03E8;
  localparam logic [11:0] STRC_TB_SEC = 12'h001;
  localparam logic [11:0] STRC_TB_MIN = 12'h03C;
  localparam logic [11:0] STRC_TB_HOUR = 12'hE10;
  localparam logic [2:0] STRC_DP_MAX = 3'h4;
  localparam logic [5:0] STRC_DIV_STEPS = 6'h30;
  // Time constants in tenths of a second, one per tens digit
  localparam logic [8:0] STRC_TC_DS [10] = '{9'h000, 9'h00D, 9'h02B, 9'h041, 9'h057,
                                             9'h071, 9'h09D, 9'h0D1, 9'h0FC, 9'h13B};
  // Per-second smoothing weight, 256 x (1 - exp(-1/tc)) for each entry above
  localparam logic [8:0] STRC_ALPHA [10] = '{9'h100, 9'h089, 9'h035, 9'h025, 9'h01C,
                                            9'h016, 9'h010, 9'h00C, 9'h00A, 9'h008};
  // Step threshold in percent per units digit, zero means never bypass
  localparam logic [6:0] STRC_STEP_PCT [10] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08,
                                               7'h0C, 7'h10, 7'h18, 7'h20, 7'h40};
  localparam logic [31:0] STRC_TOTAL_RST = 32'h0000_0000;
  localparam logic [63:0] STRC_SUM_RST = 64'h0000_0000_0000_0000;
  typedef enum logic [1:0] {STRC_ADD, STRC_SUB, STRC_BDIR, STRC_QUAD} strc_mode_type;
  typedef enum logic [1:0] {STRC_PER_SEC, STRC_PER_MIN, STRC_PER_HOUR} strc_tb_type;
endpackage

// *** strc_partner.sv ***
// Model of the pulse sensors, panel buttons and remote clear contact
`timescale 1ns/100ps
module strc_partner
(
  input wire logic i_clk,
  output logic o_pulse_a,
  output logic o_pulse_b,
  output logic o_btn_up,
  output logic o_btn_dn,
  output logic o_remote_n
);
  initial
  begin
    o_pulse_a = 1'b0;
    o_pulse_b = 1'b0;
    o_btn_up = 1'b0;
    o_btn_dn = 1'b0;
    // Open contact reads high through its pull-up
    o_remote_n = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Mark and space of hw cycles; a held level on the other line is left alone
  task automatic pulse(input bit on_b, input int n, input int hw);
    for (int k = 0; k < n; k++)
    begin
      o_pulse_a = o_pulse_a | !on_b;
      o_pulse_b = o_pulse_b | on_b;
      step(hw);
      o_pulse_a = o_pulse_a & on_b;
      o_pulse_b = o_pulse_b & !on_b;
      step(hw);
    end
  endtask

  // Direction or phase level on the second input
  task automatic set_b(input bit level);
    o_pulse_b = level;
    step(4);
  endtask

  // Both buttons together, then released long enough to pass the two sync stages
  task automatic hold_buttons(input int n);
    o_btn_up = 1'b1;
    o_btn_dn = 1'b1;
    step(n);
    o_btn_up = 1'b0;
    o_btn_dn = 1'b0;
    step(4);
  endtask

  // Terminals bridged for n cycles
  task automatic hold_remote(input int n);
    o_remote_n = 1'b0;
    step(n);
    o_remote_n = 1'b1;
    step(4);
  endtask
endmodule

// *** test_strc_counter.sv ***
// Self-checking bench of the counting core driven through the sensor model
`timescale 1ns/100ps
module test_strc_counter;
  import strc_pkg::*;
  // Short tick keeps the second-long holds and rate gates affordable
  localparam int CPM = 2;
  localparam int GATE = 1000 * CPM;
  logic i_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pa, pb, bu, bd, rem_n;
  logic [1:0] mode = 2'h0;
  logic down = 1'b0;
  logic [1:0] tb = 2'h0;
  logic [16:0] tmant = 17'h00001;
  logic [2:0] tdp = 3'h0;
  logic [16:0] rmant = 17'h00001;
  logic [2:0] rdp = 3'h0;
  logic [3:0] tens = 4'h0;
  logic [3:0] units = 4'h0;
  logic editing = 1'b0;
  logic signed [31:0] preset = 32'h0000_0000;
  logic disp = 1'b1;
  logic tclr = 1'b0;
  logic sclr = 1'b0;
  logic [2:0] ren = 3'h0;
  logic signed [31:0] o_total;
  logic [31:0] o_rate, o_secondary, o_sum_upper, o_sum_lower;
  logic o_pulse_out_en, o_alarm_en, o_loop_en;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 62837;
  int na, nb, d, n, mul;
  longint net = 0;
  longint gsum = 0;

  always #2.5 i_clk = ~i_clk;

  strc_partner P (.i_clk(i_clk), .o_pulse_a(pa), .o_pulse_b(pb), .o_btn_up(bu),
    .o_btn_dn(bd), .o_remote_n(rem_n));

  strc_counter #(.CYC_PER_MS(CPM)) DUT (
    .i_clk(i_clk), .i_arst_n(arst_n), .i_pulse_a(pa), .i_pulse_b(pb), .i_btn_up(bu),
    .i_btn_dn(bd), .i_remote_clear_terminal_a_n(rem_n), .i_count_mode(mode),
    .i_count_down(down), .i_timebase(tb), .i_total_divisor_mant(tmant),
    .i_total_divisor_dp(tdp), .i_rate_divisor_mant(rmant), .i_rate_divisor_dp(rdp),
    .i_smooth_tens(tens), .i_smooth_units(units), .i_smooth_editing(editing),
    .i_preset_load_value(preset), .i_display_mode(disp), .i_front_panel_total_clear(tclr),
    .i_front_panel_sum_clear(sclr), .i_pulse_out_enable(ren[0]), .i_alarm_enable(ren[1]),
    .i_loop_enable(ren[2]), .o_total(o_total), .o_rate(o_rate), .o_secondary(o_secondary),
    .o_sum_upper(o_sum_upper), .o_sum_lower(o_sum_lower), .o_pulse_out_en(o_pulse_out_en),
    .o_alarm_en(o_alarm_en), .o_loop_en(o_loop_en));

  function automatic int rnd(input int lim);
    return 1 + int'($unsigned($random(seed)) % lim);
  endfunction

  // Preset plus scaled count, truncated toward zero
  function automatic logic signed [31:0] exp_total(input longint cnt);
    longint p = 1;
    for (int k = 0; k < int'(tdp); k++)
      p = p * 10;
    return preset + 32'(cnt * p / longint'(tmant));
  endfunction

  // Sixteen BCD digits, ten's complement below zero
  function automatic logic [63:0] bcd(input longint v);
    logic [63:0] r = '0;
    if (v < 0)
      v = v + 64'h0023_86F2_6FC1_0000;
    for (int k = 0; k < 16; k++)
    begin
      r[4*k +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic check_counts();
    check(64'(o_total), 64'(exp_total(net)));
    check({o_sum_upper, o_sum_lower}, bcd(gsum));
  endtask

  task automatic check_en(input logic [2:0] e);
    check({61'h0, o_pulse_out_en, o_alarm_en, o_loop_en}, {61'h0, e});
  endtask

  task automatic reenable();
    ren = 3'h7;
    cyc(1);
    ren = 3'h0;
    cyc(2);
    check_en(3'h7);
  endtask

  task automatic count_a(input int c, input int hw);
    P.pulse(1'b0, c, hw);
    net += c;
    gsum += c;
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    preset = 32'(100 + rnd(1000));
    down = 1'b1;
    cyc(5);
    arst_n = 1'b1;
    cyc(300);
    check(64'(o_total), 64'(preset));
    n = rnd(20);
    P.pulse(1'b0, n, 3);
    net -= n;
    gsum -= n;
    cyc(300);
    check_counts();
    down = 1'b0;
    $display("Test down count done");
    for (int m = 0; m < 4; m++)
    begin
      mode = 2'(m);
      na = rnd(12);
      nb = rnd(12);
      cyc(4);
      if (m < 2)
      begin
        P.pulse(1'b0, na, 3);
        P.pulse(1'b1, nb, 3);
      end
      else
      begin
        P.set_b(1'b1);
        P.pulse(1'b0, na, 3);
        P.set_b(1'b0);
        P.pulse(1'b0, nb, 3);
      end
      d = (m == 0) ? na + nb : (m == 2) ? nb - na : na - nb;
      net += d;
      gsum += d;
      cyc(300);
      check_counts();
    end
    mode = 2'h0;
    $display("Test count modes done");
    // First two passes take the smallest and largest divisors
    for (int i = 0; i < 6; i++)
    begin
      reenable();
      tmant = (i == 0) ? 17'h00001 : (i == 1) ? 17'h1869F : 17'(rnd(99999));
      tdp = (i == 0) ? 3'h4 : (i == 1) ? 3'h0 : 3'(rnd(5) - 1);
      cyc(2);
      check_en(3'h0);
      reenable();
      rmant = 17'(rnd(99999));
      rdp = 3'(rnd(5) - 1);
      cyc(2);
      check_en(3'h0);
      count_a(rnd(40), 2);
      cyc(300);
      check_counts();
    end
    tmant = 17'h00001;
    tdp = 3'h0;
    rmant = 17'h00005;
    rdp = 3'h1;
    // The divisor change settles two cycles before this re-enable, so the enables hold
    cyc(2);
    reenable();
    $display("Test scaling done");
    count_a(7, 3);
    P.hold_remote(900 * CPM);
    cyc(300);
    check_counts();
    P.hold_remote(1100 * CPM);
    cyc(300);
    net = 0;
    check_counts();
    $display("Test remote clear done");
    count_a(5, 3);
    tclr = 1'b1;
    disp = 1'b0;
    P.hold_buttons(3100 * CPM);
    cyc(300);
    check_counts();
    disp = 1'b1;
    P.hold_buttons(2900 * CPM);
    P.hold_buttons(2900 * CPM);
    cyc(300);
    check_counts();
    P.hold_buttons(3100 * CPM);
    cyc(300);
    net = 0;
    check_counts();
    count_a(3, 3);
    tclr = 1'b0;
    sclr = 1'b1;
    P.hold_buttons(10100 * CPM);
    cyc(300);
    gsum = 0;
    check_counts();
    $display("Test panel clears done");
    // Period of 8 cycles puts exactly 250 pulses in every gate
    for (int t = 2; t >= 0; t--)
    begin
      tb = 2'(t);
      editing = (t == 0);
      mul = (t == 2) ? int'(STRC_TB_HOUR) : (t == 1) ? int'(STRC_TB_MIN) : int'(STRC_TB_SEC);
      count_a(3 * GATE / 8, 4);
      check(64'(o_rate), 64'(500 * mul));
      if (editing)
        check(64'(o_secondary), 64'(500 * mul));
      cyc(300);
      check_counts();
      if (!editing)
        check(64'(o_secondary), 64'(exp_total(net)));
    end
    // Strong enough smoothing to lag, weak enough that one full gate lifts it past 500
    tens = 4'h1;
    count_a(3 * GATE / 4, 2);
    check(64'(o_rate > 32'd500 && o_rate < 32'd1000), 64'h1);
    // Drop to zero rate: only the step bypass reaches exactly zero in three gates
    units = 4'h9;
    cyc(3 * GATE + 400);
    check(64'(o_rate), 64'h0);
    $display("Test rate done");
    complete_run();
  end

  initial
  begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end
endmodule
